// ---- frs_core.sv ----
`timescale 1ns/1ps
`include "frs_params.svh"
// Notes on behaviour
// - Restart needs arm command directly followed by fire command.
// - Any command after arm other than fire drops the armed state.
// - Fire received right after arm starts the software restart.
// - Legacy restart works only when its enable bit is set; default off.
// - Mode-bits clear leaves continuous read and returns to standby.
// - Mode-bits clear is eight ones on io0; io1 to io3 ignored.
// - In quad mode mode-bits clear arrives on four lines, two clocks.
// - Sleep entry accepted only while the embedded busy flag is zero.
// - Sleep entry executes only if chip select rises after bit eight.
// - After a valid sleep entry, sleep is reached within entry time.
// - In sleep only sleep exit is recognised; all else ignored.
// - After power-up the device is in standby, never sleep.
// - Sleep exit wakes the device and returns no identification value.
// - New commands accepted only after sleep exit time has elapsed.
// - Hardware restart also takes the device out of sleep.
// - In quad mode sleep commands are shifted in on four lines.
// - Restart acts on chip select rise, then needs the settle time.
// - Software restart reloads volatile state but keeps both lock bits.
module frs_core
  import frs_pkg::*;
(
  input  wire logic           i_clk,
  input  wire logic           i_rst_n,
  input  wire frs_pins_type   i_pins,
  input  wire logic           i_quad_mode,
  input  wire logic           i_busy,
  input  wire logic           i_cont_read_set,
  input  wire logic           i_legacy_wr,
  input  wire logic           i_legacy_val,
  input  wire logic           i_cfg_lock_set,
  input  wire logic           i_guard_lock_set,
  output logic      [3:0]     o_io,
  output logic      [3:0]     o_io_oe,
  output logic                o_sw_restart,
  output logic                o_legacy_en,
  output logic                o_cfg_lock,
  output logic                o_guard_lock,
  output frs_status_type      o_status
);

  localparam int ENTRY_CYC   = `FRS_SLEEP_ENTRY_CYC;
  localparam int EXIT_CYC    = `FRS_SLEEP_EXIT_CYC;
  localparam int RESTART_CYC = `FRS_RESTART_CYC;

  frs_pins_type  pins_s;
  logic          sck_d_r;
  logic          cs_d_r;
  logic          sck_rise;
  logic          cs_rise;
  logic [3:0]    cnt_r;
  logic          over_r;
  logic [7:0]    shift_r;
  logic [7:0]    shift_nxt;
  logic [3:0]    cnt_nxt;
  logic          byte_done;
  logic [7:0]    cmd_r;
  logic          exact8;
  logic          armed_r;
  logic          cont_read_r;
  logic          legacy_en_r;
  logic          cfg_lock_r;
  logic          guard_lock_r;
  logic          hw_rst;
  logic          sw_start;
  logic [11:0]   timer_r;
  logic          timer_done;
  frs_state_type state_r;
  frs_state_type state_nxt;

  frs_sync
  #(
    .W       (7),
    .RST_VAL (`FRS_PIN_IDLE)
  )
  u_pin_sync
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_pins),
    .o_sync  (pins_s)
  );

  // Edge detection on synchronised pins
  always_ff @(posedge i_clk)
  begin
    sck_d_r <= i_rst_n ? pins_s.sck : 1'b0;
    cs_d_r  <= i_rst_n ? pins_s.cs_n : 1'b1;
  end
  assign sck_rise = pins_s.sck && !sck_d_r && !pins_s.cs_n;
  assign cs_rise  = pins_s.cs_n && !cs_d_r;
  assign hw_rst   = !pins_s.hw_rst_n;

  // quad mode takes a nibble per clock
  // sleep commands share the quad path
  always_comb
  begin
    if (i_quad_mode)
    begin
      shift_nxt = {shift_r[3:0], pins_s.io};
      cnt_nxt   = cnt_r + 4'h4;
    end
    else
    begin
      shift_nxt = {shift_r[6:0], pins_s.io[0]};
      cnt_nxt   = cnt_r + 4'h1;
    end
  end

  assign byte_done = sck_rise && !over_r && (cnt_nxt == `FRS_BITS_PER_CMD);
  assign exact8    = (cnt_r == `FRS_BITS_PER_CMD) && !over_r;

  // Instruction shifter and bit count
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || pins_s.cs_n)
      {shift_r, cnt_r, over_r} <= '0;
    else if (sck_rise)
    begin
      shift_r <= shift_nxt;
      if (cnt_r >= `FRS_BITS_PER_CMD)
        over_r <= 1'b1;
      else
        cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      cmd_r <= '0;
    else if (byte_done)
      cmd_r <= shift_nxt;
  end

  // restart decided at chip select rise
  assign sw_start = cs_rise && exact8 && (state_r == ST_STANDBY) && !cont_read_r &&
                    (((cmd_r == `FRS_CMD_FIRE) && armed_r) ||
                     ((cmd_r == `FRS_CMD_LEGACY) && legacy_en_r));

  // arm only on an exact arm command
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || hw_rst || sw_start)
      armed_r <= 1'b0;
    else if (state_r == ST_STANDBY && !cont_read_r)
    begin
      if (byte_done && shift_nxt != `FRS_CMD_FIRE)
        armed_r <= 1'b0;
      else if (cs_rise && exact8 && cmd_r == `FRS_CMD_ARM)
        armed_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || hw_rst || sw_start)
      cont_read_r <= 1'b0;
    else if (byte_done && shift_nxt == `FRS_CMD_MODE_CLEAR)
      cont_read_r <= 1'b0;
    else if (i_cont_read_set && state_r == ST_STANDBY)
      cont_read_r <= 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || hw_rst || sw_start)
      legacy_en_r <= `FRS_LEGACY_RST;
    else if (i_legacy_wr && state_r == ST_STANDBY)
      legacy_en_r <= i_legacy_val;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || hw_rst)
      {cfg_lock_r, guard_lock_r} <= 2'b00;
    else if (state_r == ST_STANDBY)
    begin
      if (i_cfg_lock_set)
        cfg_lock_r <= 1'b1;
      if (i_guard_lock_set)
        guard_lock_r <= 1'b1;
    end
  end

  assign timer_done = (state_r == ST_SLEEP_ENTRY && timer_r == 12'(ENTRY_CYC - 1)) ||
                      (state_r == ST_SLEEP_EXIT && timer_r == 12'(EXIT_CYC - 1)) ||
                      (state_r == ST_RESTART && timer_r == 12'(RESTART_CYC - 1));

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_STANDBY:
      begin
        if (sw_start)
          state_nxt = ST_RESTART;
        // sleep entry needs idle busy flag
        // exact eight bits before cs rise
        else if (cs_rise && exact8 && !cont_read_r && !i_busy &&
                 cmd_r == `FRS_CMD_SLEEP_ENTRY)
          state_nxt = ST_SLEEP_ENTRY;
      end
      ST_SLEEP_ENTRY:
        if (timer_done)
          state_nxt = ST_SLEEP;
      ST_SLEEP:
        if (cs_rise && exact8 && cmd_r == `FRS_CMD_SLEEP_EXIT)
          state_nxt = ST_SLEEP_EXIT;
      ST_SLEEP_EXIT:
        if (timer_done)
          state_nxt = ST_STANDBY;
      ST_RESTART:
        if (timer_done)
          state_nxt = ST_STANDBY;
    endcase
    if (hw_rst)
      state_nxt = ST_RESTART;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      state_r <= ST_STANDBY;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || state_nxt != state_r || hw_rst)
      timer_r <= '0;
    else if (state_r != ST_STANDBY && state_r != ST_SLEEP)
      timer_r <= timer_r + 12'h001;
  end

  // Registered outputs
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      {o_io, o_io_oe, o_sw_restart, o_legacy_en, o_cfg_lock, o_guard_lock, o_status} <= '0;
    else
    begin
      o_io                  <= '0;
      o_io_oe               <= '0;
      o_sw_restart          <= sw_start;
      o_legacy_en           <= legacy_en_r;
      o_cfg_lock            <= cfg_lock_r;
      o_guard_lock          <= guard_lock_r;
      o_status.sleeping     <= (state_r == ST_SLEEP);
      o_status.ready        <= (state_r == ST_STANDBY);
      o_status.armed        <= armed_r;
      o_status.cont_read    <= cont_read_r;
      o_status.restart_busy <= (state_r == ST_RESTART);
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_entry_start;
    $rose(state_r == ST_SLEEP_ENTRY);
  endsequence
  sequence s_exit_start;
    $rose(state_r == ST_SLEEP_EXIT);
  endsequence
  a_arm_dropped: assert property (
    byte_done && armed_r && shift_nxt != `FRS_CMD_FIRE && state_r == ST_STANDBY
    |=> !armed_r)
    else $error("armed state kept after other command");
  a_fire_restart: assert property (
    cs_rise && exact8 && armed_r && cmd_r == `FRS_CMD_FIRE && state_r == ST_STANDBY
    && !cont_read_r && !hw_rst
    |=> state_r == ST_RESTART && o_sw_restart)
    else $error("fire after arm did not restart");
  a_legacy_gate: assert property (
    cs_rise && cmd_r == `FRS_CMD_LEGACY && !legacy_en_r && !hw_rst
    && !(armed_r && cmd_r == `FRS_CMD_FIRE)
    |=> state_r != ST_RESTART)
    else $error("legacy restart while disabled");
  a_mode_clear: assert property (
    byte_done && shift_nxt == `FRS_CMD_MODE_CLEAR && !i_cont_read_set
    |=> !cont_read_r ##1 !o_status.cont_read)
    else $error("continuous read not left");
  a_sleep_busy: assert property (
    state_r == ST_STANDBY && cs_rise && i_busy && !sw_start && !hw_rst
    |=> state_r == ST_STANDBY)
    else $error("sleep entry while busy");
  a_sleep_exact: assert property (
    state_r == ST_STANDBY && cs_rise && !exact8 |=> state_r != ST_SLEEP_ENTRY)
    else $error("sleep entry without exact eight bits");
  a_entry_time: assert property (
    s_entry_start |-> ##[0:ENTRY_CYC] (state_r == ST_SLEEP || state_r == ST_RESTART))
    else $error("sleep not reached in entry time");
  a_sleep_ignore: assert property (
    state_r == ST_SLEEP && cs_rise && cmd_r != `FRS_CMD_SLEEP_EXIT && !hw_rst
    |=> state_r == ST_SLEEP && $stable(armed_r))
    else $error("command acted on in sleep");
  a_power_up: assert property (
    !$past(i_rst_n) |-> state_r == ST_STANDBY && !o_status.sleeping)
    else $error("not in standby after reset");
  a_exit_time: assert property (
    s_exit_start |-> !o_status.ready [*2] ##[0:EXIT_CYC] state_r != ST_SLEEP_EXIT)
    else $error("sleep exit timing wrong");
  a_hw_wake: assert property (
    hw_rst |=> state_r == ST_RESTART && !armed_r)
    else $error("hardware restart ignored");
  a_locks_kept: assert property (
    sw_start && !hw_rst |=> $stable(cfg_lock_r) && $stable(guard_lock_r)
    && legacy_en_r == `FRS_LEGACY_RST)
    else $error("software restart changed lock bits");
  a_lines_idle: assert property (
    o_status.sleeping |-> o_io_oe == 4'h0)
    else $error("lines driven in sleep");
endmodule

// ---- frs_params.svh ----
`ifndef FRS_PARAMS_SVH
`define FRS_PARAMS_SVH

// Instruction codes
`define FRS_CMD_ARM          8'h66
`define FRS_CMD_FIRE         8'h99
`define FRS_CMD_LEGACY       8'hF0
`define FRS_CMD_MODE_CLEAR   8'hFF
`define FRS_CMD_SLEEP_ENTRY  8'hB9
`define FRS_CMD_SLEEP_EXIT   8'hAB

// Field layout and reset values
`define FRS_BITS_PER_CMD     4'h8
`define FRS_PIN_IDLE         7'h60
`define FRS_LEGACY_RST       1'b0

// Timing, in ns, and clock period
`define FRS_CLK_NS           5
`define FRS_T_SLEEP_ENTRY_NS 3000
`define FRS_T_SLEEP_EXIT_NS  3000
`define FRS_T_RESTART_NS     3000

// Longest time rounds down, least times round up
`define FRS_SLEEP_ENTRY_CYC  (`FRS_T_SLEEP_ENTRY_NS / `FRS_CLK_NS)
`define FRS_SLEEP_EXIT_CYC   ((`FRS_T_SLEEP_EXIT_NS + `FRS_CLK_NS - 1) / `FRS_CLK_NS)
`define FRS_RESTART_CYC      ((`FRS_T_RESTART_NS + `FRS_CLK_NS - 1) / `FRS_CLK_NS)

`endif

// ---- frs_pkg.sv ----
package frs_pkg;

  typedef enum logic [2:0]
  {
    ST_STANDBY,
    ST_SLEEP_ENTRY,
    ST_SLEEP,
    ST_SLEEP_EXIT,
    ST_RESTART
  } frs_state_type;

  typedef struct packed
  {
    logic       hw_rst_n;
    logic       cs_n;
    logic       sck;
    logic [3:0] io;
  } frs_pins_type;

  typedef struct packed
  {
    logic sleeping;
    logic ready;
    logic armed;
    logic cont_read;
    logic restart_busy;
  } frs_status_type;

endpackage

// ---- frs_sync.sv ----
`timescale 1ns/1ps
module frs_sync
#(
  parameter int               W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
)
(
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  // Two-stage synchroniser
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      meta_r <= RST_VAL;
      o_sync <= RST_VAL;
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule

// ---- frs_host.sv ----
`timescale 1ns/1ps
`include "frs_params.svh"
module frs_host
  import frs_pkg::*;
(
  input  wire logic    i_clk,
  output frs_pins_type o_pins
);
  initial o_pins = `FRS_PIN_IDLE;

  task automatic frame(input logic [7:0] b, input logic q, input int n);
    logic [3:0] v;
    @(negedge i_clk);
    o_pins.cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      v = q ? (i[0] ? b[3:0] : b[7:4]) : {3'($urandom()), b[7 - i % 8]};
      o_pins.io = v;
      repeat (16) @(negedge i_clk);
      o_pins.sck = 1'b1;
      repeat (16) @(negedge i_clk);
      o_pins.sck = 1'b0;
    end
    repeat (16) @(negedge i_clk);
    o_pins.cs_n = 1'b1;
    o_pins.io = ~o_pins.io;
  endtask

  task automatic hw_restart();
    @(negedge i_clk);
    o_pins.hw_rst_n = 1'b0;
    repeat (20) @(negedge i_clk);
    o_pins.hw_rst_n = 1'b1;
  endtask
endmodule

// ---- flash_reset_and_sleep_cmds_tb_top.sv ----
`timescale 1ns/1ps
module flash_reset_and_sleep_cmds_tb_top
  import frs_pkg::*;
;
  logic           i_clk = 1'b0;
  logic           i_rst_n = 1'b0;
  frs_pins_type   pins;
  logic           i_quad_mode = 1'b0;
  logic           i_busy = 1'b0;
  logic           i_cont_read_set = 1'b0;
  logic           i_legacy_wr = 1'b0;
  logic           i_legacy_val = 1'b0;
  logic           i_cfg_lock_set = 1'b0;
  logic           i_guard_lock_set = 1'b0;
  logic [3:0]     o_io;
  logic [3:0]     o_io_oe;
  logic           o_sw_restart;
  logic           o_legacy_en;
  logic           o_cfg_lock;
  logic           o_guard_lock;
  frs_status_type o_status;
  logic [7:0]     seen = 8'h00;
  logic [7:0]     xr = 8'h00;
  logic [2:0]     fl = 3'h0;
  logic [7:0]     rnd;
  logic [23:0]    obs;
  logic [23:0]    e;
  logic [23:0]    exp_q[$];
  logic [7:0]     ign[5] = '{8'h66, 8'h99, 8'hF0, 8'hFF, 8'h05};
  int             n_mismatch = 0;
  int             n_checks = 0;
  event           chk;

  initial forever #2.5 i_clk = ~i_clk;

  frs_host host (.i_clk(i_clk), .o_pins(pins));

  frs_core DUT
  (
    .i_clk           (i_clk),
    .i_rst_n         (i_rst_n),
    .i_pins          (pins),
    .i_quad_mode     (i_quad_mode),
    .i_busy          (i_busy),
    .i_cont_read_set (i_cont_read_set),
    .i_legacy_wr     (i_legacy_wr),
    .i_legacy_val    (i_legacy_val),
    .i_cfg_lock_set  (i_cfg_lock_set),
    .i_guard_lock_set(i_guard_lock_set),
    .o_io            (o_io),
    .o_io_oe         (o_io_oe),
    .o_sw_restart    (o_sw_restart),
    .o_legacy_en     (o_legacy_en),
    .o_cfg_lock      (o_cfg_lock),
    .o_guard_lock    (o_guard_lock),
    .o_status        (o_status)
  );

  always @(negedge i_clk)
    if (o_sw_restart === 1'b1)
      seen <= seen + 8'h01;

  assign obs = {o_io_oe, o_io, seen, o_legacy_en, o_cfg_lock, o_guard_lock, o_status};

  // Compares oldest note against outputs
  initial
  begin
    forever
    begin
      @(chk);
      while (exp_q.size() > 0)
      begin
        e = exp_q.pop_front();
        n_checks++;
        if (obs !== e)
        begin
          n_mismatch++;
          $display("MISMATCH t=%0t exp=%h got=%h", $time, e, obs);
        end
      end
    end
  end

  task automatic conclude();
    @(posedge i_clk);
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input int w, input logic [4:0] st);
    repeat (w) @(negedge i_clk);
    exp_q.push_back({8'h00, xr, fl, st});
    -> chk;
  endtask

  task automatic cmd(input logic [7:0] b, input logic q, input int n, input int w,
                     input logic [4:0] st);
    @(negedge i_clk);
    i_quad_mode = q;
    host.frame(b, q, n);
    check(w, st);
  endtask

  task automatic pulse(input logic [3:0] m);
    @(negedge i_clk);
    {i_cont_read_set, i_legacy_wr, i_cfg_lock_set, i_guard_lock_set} = m;
    i_legacy_val = m[2];
    @(negedge i_clk);
    {i_cont_read_set, i_legacy_wr, i_cfg_lock_set, i_guard_lock_set} = 4'h0;
  endtask

  initial
  begin
    repeat (100000) @(posedge i_clk);
    n_mismatch++;
    conclude();
  end

  initial
  begin
    void'($urandom(32'h1712));
    repeat (6) @(negedge i_clk);
    i_rst_n = 1'b1;
    check(5, 5'h08);
    $display("test power_up done");
    cmd(8'h66, 1'b0, 8, 10, 5'h0C);
    xr = xr + 8'h01;
    cmd(8'h99, 1'b0, 8, 10, 5'h01);
    check(700, 5'h08);
    rnd = 8'($urandom_range(8'h01, 8'h5F));
    cmd(8'h66, 1'b0, 8, 10, 5'h0C);
    cmd(rnd, 1'b0, 8, 10, 5'h08);
    cmd(8'h99, 1'b0, 8, 700, 5'h08);
    $display("test arm_fire done");
    cmd(8'hF0, 1'b0, 8, 700, 5'h08);
    pulse(4'h4);
    pulse(4'h2);
    pulse(4'h1);
    fl = 3'h7;
    check(5, 5'h08);
    xr = xr + 8'h01;
    fl = 3'h3;
    cmd(8'hF0, 1'b0, 8, 700, 5'h08);
    $display("test legacy done");
    pulse(4'h8);
    check(10, 5'h0A);
    cmd(8'hB9, 1'b0, 8, 700, 5'h0A);
    cmd(8'hFF, 1'b0, 8, 10, 5'h08);
    pulse(4'h8);
    cmd(8'hFF, 1'b1, 2, 10, 5'h08);
    cmd(8'h66, 1'b1, 2, 10, 5'h0C);
    xr = xr + 8'h01;
    cmd(8'h99, 1'b1, 2, 700, 5'h08);
    $display("test mode_clear done");
    i_busy = 1'b1;
    cmd(8'hB9, 1'b0, 8, 700, 5'h08);
    i_busy = 1'b0;
    cmd(8'hB9, 1'b0, 9, 700, 5'h08);
    cmd(8'hB9, 1'b0, 8, 700, 5'h10);
    foreach (ign[k])
      cmd(ign[k], 1'b0, 8, 700, 5'h10);
    cmd(8'hAB, 1'b0, 8, 300, 5'h00);
    check(400, 5'h08);
    cmd(8'h99, 1'b0, 8, 700, 5'h08);
    cmd(8'hB9, 1'b1, 2, 700, 5'h10);
    cmd(8'hAB, 1'b1, 2, 700, 5'h08);
    $display("test sleep done");
    cmd(8'hB9, 1'b0, 8, 700, 5'h10);
    host.hw_restart();
    fl = 3'h0;
    check(700, 5'h08);
    $display("test hw_restart done");
    conclude();
  end
endmodule
